// ===== rtl/tkc_pkg.sv
// Shared constants, types and helpers of the tick counter block
`default_nettype none
package tkc_pkg;
   localparam int CNT_W = 18;
   localparam int CM_AW = 15;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam logic [CNT_W-1:0] CNT_MAX = 18'h3FFFF;
   localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;
   // Control memory locations, octal 15, 14, 12 and 13
   localparam logic [CM_AW-1:0] CNT_LOC = 15'h000D;
   localparam logic [CM_AW-1:0] CMP_LOC = 15'h000C;
   localparam logic [CM_AW-1:0] VEC_MATCH = 15'h000A;
   localparam logic [CM_AW-1:0] VEC_WRAP = 15'h000B;
   localparam logic [CM_AW-1:0] VEC_NONE = 15'h0000;
   localparam int CM_CHAN_LO = 2;
   localparam int CM_SEL_BIT = 0;
   localparam logic [1:0] CHAN_SET = 2'h3;
   localparam logic [1:0] CHAN_CLR = 2'h0;
   // Register byte offsets
   localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] REG_ARM = 8'h04;
   localparam logic [APB_AW-1:0] REG_STAT = 8'h08;
   localparam logic [APB_AW-1:0] REG_CNT = 8'h0C;
   localparam int CTRL_DISC = 0;
   localparam int STAT_ARM = 0;
   localparam int STAT_MATCH = 1;
   localparam int STAT_WRAP = 2;
   localparam int STAT_MISM = 3;
   localparam int STAT_BUSY = 4;
   // Arm instruction code 50:14 written to the arm register
   localparam int FC_MAJ_LO = 6;
   localparam int FC_MIN_LO = 0;
   localparam logic [5:0] FC_MAJOR = 6'h28;
   localparam logic [5:0] FC_MINOR = 6'h0C;
   localparam logic [APB_DW-1:0] RD_ZERO = 32'h00000000;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [CM_AW-1:0] addr;
      logic [CNT_W-1:0] wdata;
   } tkc_cm_req_t;

   localparam tkc_cm_req_t CM_IDLE = '{rd: 1'b0, wr: 1'b0, addr: 15'h0000, wdata: 18'h00000};

   function automatic logic [CM_AW-1:0] tkc_cm_addr(input logic [1:0] chan, input logic sel_cnt);
      logic [CM_AW-1:0] a;
      a = VEC_NONE;
      a[CM_CHAN_LO +: 2] = chan;
      a[CM_SEL_BIT] = sel_cnt;
      return a;
   endfunction : tkc_cm_addr
endpackage : tkc_pkg
`default_nettype wire

// ===== rtl/tkc_tick_sync.sv
// Oscillator pin synchroniser giving one pulse per tick
`default_nettype none
module tkc_tick_sync (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic tick_i,
   output logic pulse_o
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;
   logic pulse_ff;
   wire logic nxt_pulse = sync_ff & ~prev_ff;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
         pulse_ff <= 1'b0;
      end else begin
         meta_ff <= tick_i;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         pulse_ff <= nxt_pulse;
      end
   end

   assign pulse_o = pulse_ff;
endmodule : tkc_tick_sync
`default_nettype wire

// ===== rtl/tkc_tick_counter.sv
// Tick service sequencer with match and wrap interrupts and APB registers
`default_nettype none
// Function
// - Every oscillator tick while connected raises a service request that adds one to the stored count.
// - Each service adds exactly one to the count word at octal 15 of control memory.
// - The count is 18 bits, bit 0 worth 1/1024 s and bit 10 worth one second.
// - While disconnected, ticks raise no request and the count stays frozen.
// - Executing arm instruction 50:14 sets the match arm flag in its own sequence.
// - While armed, an equal compare word at octal 14 sets the match flag, vector octal 12.
// - Setting the match flag clears the arm flag, so each match needs a fresh arm.
// - Incrementing 777777 wraps to zero and sets the wrap flag, vector octal 13.
// - Service runs with the service flag set and first reads the current count.
// - Address bits 3 and 2 come from the channel flags; bit 0 selects count over compare.
// - The count is loaded into B and a second read fetches the compare word.
// - Equality leaves the mismatch flag clear, and it matters only when armed.
// - B plus one is written back to the count word in a third memory cycle.
// - The write-back cycle suppresses read gating so the old count is replaced.
// - The match flag is set only when armed and the mismatch flag is clear.
module tkc_tick_counter
   import tkc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic TICK_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [APB_AW-1:0] PADDR_I,
   input wire logic [APB_DW-1:0] PWDATA_I,
   output logic [APB_DW-1:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [CNT_W-1:0] CM_RDATA_I,
   output tkc_cm_req_t CM_REQ_O,
   output logic MATCH_IRQ_O,
   output logic WRAP_IRQ_O,
   output logic [CM_AW-1:0] IRQ_VEC_O
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_RD_CNT,
      ST_LD_B,
      ST_CMP,
      ST_WB,
      ST_FLAG,
      ST_DONE
   } tkc_state_t;

   tkc_state_t state_ff;
   tkc_state_t nxt_state;
   logic tick_pulse;
   logic req_ff;
   logic svc_ff;
   logic [1:0] chan_ff;
   logic [CNT_W-1:0] b_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic mism_ff;
   logic arm_ff;
   logic match_ff;
   logic wrap_ff;
   logic disc_ff;
   tkc_cm_req_t cm_ff;
   tkc_cm_req_t nxt_cm;
   logic [APB_DW-1:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [CM_AW-1:0] vec_ff;

   tkc_tick_sync u_sync (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .tick_i(TICK_I),
      .pulse_o(tick_pulse)
   );

   // APB decode; one wait state so every bus output is a flop
   wire logic apb_acc = PSEL_I & PENABLE_I;
   wire logic apb_done = apb_acc & pready_ff;
   wire logic apb_wr = apb_done & PWRITE_I;
   wire logic hit_ctrl = (PADDR_I == REG_CTRL);
   wire logic hit_arm = (PADDR_I == REG_ARM);
   wire logic hit_stat = (PADDR_I == REG_STAT);
   wire logic hit_cnt = (PADDR_I == REG_CNT);
   wire logic hit_any = hit_ctrl | hit_arm | hit_stat | hit_cnt;
   wire logic wr_ctrl = apb_wr & hit_ctrl;
   wire logic wr_stat = apb_wr & hit_stat;
   wire logic fc_ok = (PWDATA_I[FC_MAJ_LO +: 6] == FC_MAJOR) & (PWDATA_I[FC_MIN_LO +: 6] == FC_MINOR);
   wire logic arm_set = apb_wr & hit_arm & fc_ok;
   wire logic clr_match = wr_stat & PWDATA_I[STAT_MATCH];
   wire logic clr_wrap = wr_stat & PWDATA_I[STAT_WRAP];

   wire logic busy = (state_ff != ST_IDLE);
   wire logic [APB_DW-1:0] stat_word = {27'h0000000, busy, mism_ff, wrap_ff, match_ff, arm_ff};
   wire logic [APB_DW-1:0] ctrl_word = {31'h00000000, disc_ff};
   wire logic [APB_DW-1:0] cnt_word = {14'h0000, cnt_ff};
   wire logic [APB_DW-1:0] rd_mux = hit_ctrl ? ctrl_word :
                                    hit_stat ? stat_word :
                                    hit_cnt ? cnt_word : RD_ZERO;

   // Service sequencing and memory cycle selection
   wire logic start = req_ff & ~busy;
   wire logic [CNT_W-1:0] b_inc = b_ff + CNT_ONE;
   wire logic set_match = (state_ff == ST_FLAG) & arm_ff & ~mism_ff;
   wire logic set_wrap = (state_ff == ST_FLAG) & (b_ff == CNT_MAX);
   wire logic nxt_match = set_match | (match_ff & ~clr_match);
   wire logic nxt_wrap = set_wrap | (wrap_ff & ~clr_wrap);

   always_comb begin
      nxt_state = state_ff;
      nxt_cm = CM_IDLE;
      case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            nxt_state = ST_RD_CNT;
            nxt_cm.rd = 1'b1;
            nxt_cm.addr = tkc_cm_addr(chan_ff, 1'b1);
         end
         ST_RD_CNT: begin
            nxt_state = ST_LD_B;
            nxt_cm.rd = 1'b1;
            nxt_cm.addr = tkc_cm_addr(chan_ff, 1'b0);
         end
         ST_LD_B: begin
            nxt_state = ST_CMP;
         end
         ST_CMP: begin
            nxt_state = ST_WB;
            nxt_cm.wr = 1'b1;
            nxt_cm.addr = tkc_cm_addr(chan_ff, 1'b1);
            nxt_cm.wdata = b_inc;
         end
         ST_WB: begin
            nxt_state = ST_FLAG;
         end
         ST_FLAG: begin
            nxt_state = ST_DONE;
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   wire logic [CM_AW-1:0] nxt_vec = nxt_match ? VEC_MATCH : nxt_wrap ? VEC_WRAP : VEC_NONE;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state_ff <= ST_IDLE;
         cm_ff <= CM_IDLE;
      end else begin
         state_ff <= nxt_state;
         cm_ff <= nxt_cm;
      end
   end

   // A new tick set wins over the clear taken in the count read cycle.
   // A tick landing in the setup cycle merges with the pending request;
   // ticks are hundreds of thousands of cycles apart, so this cannot happen in use.
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         req_ff <= 1'b0;
      end else if (tick_pulse & ~disc_ff) begin
         req_ff <= 1'b1;
      end else if (state_ff == ST_RD_CNT) begin
         req_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         svc_ff <= 1'b0;
         chan_ff <= CHAN_CLR;
      end else if (start) begin
         svc_ff <= 1'b1;
         chan_ff <= CHAN_SET;
      end else if (state_ff == ST_DONE) begin
         svc_ff <= 1'b0;
         chan_ff <= CHAN_CLR;
      end
   end

   // Memory data arrives the cycle after its read strobe
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         b_ff <= CNT_MAX;
         mism_ff <= 1'b0;
         cnt_ff <= CM_IDLE.wdata;
      end else begin
         if (state_ff == ST_LD_B) begin
            b_ff <= CM_RDATA_I;
         end
         if (state_ff == ST_CMP) begin
            mism_ff <= (b_ff != CM_RDATA_I);
         end
         if (state_ff == ST_WB) begin
            cnt_ff <= cm_ff.wdata;
         end
      end
   end

   // Arm from software wins over the clear caused by a match
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         arm_ff <= 1'b0;
         match_ff <= 1'b0;
         wrap_ff <= 1'b0;
         vec_ff <= VEC_NONE;
         disc_ff <= 1'b0;
      end else begin
         if (arm_set) begin
            arm_ff <= 1'b1;
         end else if (set_match) begin
            arm_ff <= 1'b0;
         end
         match_ff <= nxt_match;
         wrap_ff <= nxt_wrap;
         vec_ff <= nxt_vec;
         if (wr_ctrl) begin
            disc_ff <= PWDATA_I[CTRL_DISC];
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pready_ff <= 1'b0;
         prdata_ff <= RD_ZERO;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= apb_acc & ~pready_ff;
         prdata_ff <= (apb_acc & ~pready_ff & ~PWRITE_I) ? rd_mux : RD_ZERO;
         pslverr_ff <= apb_acc & ~pready_ff & ~hit_any;
      end
   end

   assign PRDATA_O = prdata_ff;
   assign PREADY_O = pready_ff;
   assign PSLVERR_O = pslverr_ff;
   assign CM_REQ_O = cm_ff;
   assign MATCH_IRQ_O = match_ff;
   assign WRAP_IRQ_O = wrap_ff;
   assign IRQ_VEC_O = vec_ff;

   a_tick_request: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      tick_pulse && !disc_ff |=> req_ff ##[1:8] (state_ff == ST_RD_CNT))
      else $error("tick did not lead to a count read");

   a_disc_freeze: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      tick_pulse && disc_ff && !req_ff |=> !req_ff)
      else $error("tick raised a request while disconnected");

   a_count_read: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == ST_RD_CNT |-> cm_ff.rd && !cm_ff.wr && cm_ff.addr == CNT_LOC && svc_ff)
      else $error("count read not at count location");

   a_compare_read: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == ST_LD_B |-> cm_ff.rd && cm_ff.addr == CMP_LOC ##1 b_ff == $past(CM_RDATA_I))
      else $error("compare read or B load wrong");

   a_write_back: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == ST_WB |-> cm_ff.wr && !cm_ff.rd && cm_ff.addr == CNT_LOC
         && cm_ff.wdata == b_inc)
      else $error("write-back is not the count plus one");

   a_mismatch_eval: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == ST_CMP |=> mism_ff == ($past(b_ff) != $past(CM_RDATA_I)))
      else $error("mismatch flag does not reflect compare");

   a_match_cause: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $rose(match_ff) |-> $past(state_ff) == ST_FLAG && $past(arm_ff) && !$past(mism_ff))
      else $error("match set without arm and equality");

   a_match_disarm: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      set_match && !arm_set |=> match_ff && !arm_ff && IRQ_VEC_O == VEC_MATCH)
      else $error("match did not disarm or vector");

   a_wrap_flag: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == ST_CMP && b_ff == CNT_MAX |=> cm_ff.wdata == CM_IDLE.wdata ##2 wrap_ff)
      else $error("wrap did not zero the count and flag it");

   a_arm_insn: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      arm_set |=> arm_ff)
      else $error("arm instruction did not arm");

   a_single_pulse: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      tick_pulse |=> !tick_pulse)
      else $error("tick pulse longer than one cycle");

   a_wrap_cause: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      $rose(wrap_ff) |-> $past(state_ff) == ST_FLAG && $past(b_ff) == CNT_MAX)
      else $error("wrap flag set without a full count");

   a_strobe_exclusive: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      cm_ff.wr |-> !cm_ff.rd && state_ff == ST_WB)
      else $error("write-back overlaps a memory read");

   a_chan_address: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      svc_ff |-> chan_ff == CHAN_SET)
      else $error("channel flags clear during service");

   a_count_update: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == ST_FLAG |-> cnt_ff == $past(cm_ff.wdata))
      else $error("count readback not the written-back value");

   a_vec_match: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      match_ff |-> IRQ_VEC_O == VEC_MATCH)
      else $error("match pending without its vector");

   a_vec_wrap: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      wrap_ff && !match_ff |-> IRQ_VEC_O == VEC_WRAP)
      else $error("wrap pending without its vector");

   a_request_clear: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == ST_RD_CNT && !(tick_pulse && !disc_ff) |=> !req_ff)
      else $error("request not cleared when service read the count");

   a_unarmed_silent: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == ST_FLAG && !arm_ff && !match_ff |=> !match_ff)
      else $error("match flag set while not armed");
endmodule : tkc_tick_counter
`default_nettype wire

// ===== testbench/tkc_cm_model.sv
// Control memory model answering one cycle after each read strobe
`default_nettype none
module tkc_cm_model
   import tkc_pkg::*;
(
   input wire logic clk_i,
   input wire tkc_cm_req_t req_i,
   output logic [CNT_W-1:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [CNT_W-1:0] mem [0:15];
   // Known contents, so a compare before software stores a word is not unknown
   initial begin
      rdata_o = '0;
      for (int j = 0; j < 16; j++) mem[j] = '0;
   end
   always @(posedge clk_i) begin
      if (req_i.rd === 1'b1) begin
         rdata_o <= mem[req_i.addr[3:0]];
      end else begin
         // Data lapses after its cycle, so a late sample sees garbage
         rdata_o <= ~rdata_o;
      end
      if (req_i.wr === 1'b1) begin
         mem[req_i.addr[3:0]] <= req_i.wdata;
      end
   end
endmodule : tkc_cm_model
`default_nettype wire

// ===== testbench/tkc_tick_counter_bench.sv
// Self-checking bench for the tick counter block
`default_nettype none
module tkc_tick_counter_bench import tkc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rstn, tick, psel, pen, pwr, pready, pslverr, m_irq, w_irq;
   logic [APB_AW-1:0] paddr;
   logic [APB_DW-1:0] pwdata, prdata;
   logic [CNT_W-1:0] cm_rdata;
   logic [CM_AW-1:0] vec;
   tkc_cm_req_t cm_req;
   int n_errors = 0;
   int compares = 0;
   int seed = 65;
   logic [APB_DW:0] rd_q[$];
   logic [CNT_W-1:0] wr_q[$];
   always #2.5 clk = ~clk;
   tkc_tick_counter dut (.CLK_I(clk), .RSTN_I(rstn), .TICK_I(tick), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .CM_RDATA_I(cm_rdata), .CM_REQ_O(cm_req), .MATCH_IRQ_O(m_irq),
      .WRAP_IRQ_O(w_irq), .IRQ_VEC_O(vec));
   tkc_cm_model cm (.clk_i(clk), .req_i(cm_req), .rdata_o(cm_rdata));

   task automatic check(input logic [APB_DW:0] seen, input logic [APB_DW:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d,
                      input logic [APB_DW:0] exp);
      int i;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) rd_q.push_back(exp);
      @(posedge clk);
      pen <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         n_errors++;
         final_report();
      end else begin
         psel <= 1'b0;
         pen <= 1'b0;
         // Idle edge so the next setup never re-drives psel in this time step
         @(posedge clk);
      end
   endtask : apb

   // Preset the count word, then hold the pin high for several cycles
   task automatic tick_once(input logic [CNT_W-1:0] pre, input logic conn);
      cm.mem[CNT_LOC[3:0]] = pre;
      if (conn) wr_q.push_back(pre + CNT_ONE);
      @(posedge clk);
      tick <= 1'b1;
      repeat (4) @(posedge clk);
      tick <= 1'b0;
      repeat (16) @(posedge clk);
   endtask : tick_once

   always @(posedge clk) begin
      if (pready === 1'b1 && pwr === 1'b0) check({pslverr, prdata}, rd_q.pop_front());
      if (cm_req.rd === 1'b1) check(33'(cm_req.addr == CNT_LOC || cm_req.addr == CMP_LOC), 33'h1);
      if (cm_req.wr === 1'b1) begin
         check(33'(cm_req.addr), 33'(CNT_LOC));
         check(33'(wr_q.size() > 0), 33'h1);
         check(33'(cm_req.wdata), 33'(wr_q.pop_front()));
      end
   end

   initial begin
      rstn = 1'b0;
      tick = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, REG_CNT, RD_ZERO, {1'b0, RD_ZERO});
      tick_once(18'h00005, 1'b1);
      apb(1'b0, REG_CNT, RD_ZERO, 33'h6);
      for (int k = 0; k < 6; k++) tick_once(18'($random(seed)), 1'b1);
      apb(1'b1, REG_CTRL, 32'h1, '0);
      apb(1'b0, REG_CTRL, RD_ZERO, 33'h1);
      tick_once(18'h00100, 1'b0);
      apb(1'b1, REG_CTRL, RD_ZERO, '0);
      cm.mem[CMP_LOC[3:0]] = 18'h00009;
      apb(1'b1, REG_STAT, 32'h6, '0);
      apb(1'b1, REG_ARM, 32'h00000A0D, '0);
      tick_once(18'h00009, 1'b1);
      check(33'(m_irq), 33'h0);
      apb(1'b1, REG_ARM, 32'h00000A0C, '0);
      apb(1'b0, REG_STAT, RD_ZERO, 33'h1);
      tick_once(18'h00008, 1'b1);
      apb(1'b0, REG_STAT, RD_ZERO, 33'h9);
      tick_once(18'h00009, 1'b1);
      check(33'({m_irq, vec}), 33'({1'b1, VEC_MATCH}));
      apb(1'b0, REG_STAT, RD_ZERO, 33'h2);
      apb(1'b1, REG_STAT, 32'h2, '0);
      tick_once(18'h00009, 1'b1);
      check(33'(m_irq), 33'h0);
      tick_once(CNT_MAX, 1'b1);
      check(33'({w_irq, vec}), 33'({1'b1, VEC_WRAP}));
      apb(1'b0, REG_STAT, RD_ZERO, 33'hC);
      apb(1'b1, REG_STAT, 32'h4, '0);
      check(33'({w_irq, vec}), 33'h0);
      apb(1'b1, 8'h44, 32'hFFFF, '0);
      apb(1'b0, 8'h40, RD_ZERO, {1'b1, RD_ZERO});
      check(33'(wr_q.size()), 33'h0);
      final_report();
   end
endmodule : tkc_tick_counter_bench
`default_nettype wire
